// ===== hw/iedc_params.svh
/*
  offsets, field positions and reset values of the i2c event/dma/clock block.
  assumes a 32-bit apb with one aligned word per register.
*/
`ifndef IEDC_PARAMS_SVH
`define IEDC_PARAMS_SVH
// ==========================================================
// register byte offsets
`define IEDC_OFF_CLK 12'h000
`define IEDC_OFF_MOD 12'h004
`define IEDC_OFF_CTL 12'h008
`define IEDC_OFF_INTF 12'h00c
`define IEDC_OFF_INTE 12'h010
`define IEDC_OFF_DMARX 12'h014
`define IEDC_OFF_DMATX 12'h018
`define IEDC_OFF_TXD 12'h01c
`define IEDC_OFF_RXD 12'h020
`define IEDC_OFF_OADR 12'h024
// ==========================================================
// field positions
`define IEDC_CLK_DEBUG_RUN 8
`define IEDC_CLK_DIV_LO 4
`define IEDC_CLK_SRC_LO 0
`define IEDC_MOD_OWN_ADDRESS_WIDTH 2
`define IEDC_MOD_GENERAL_CALL_ENABLE 1
`define IEDC_CTL_MST 5
`define IEDC_CTL_START_REQUEST 2
`define IEDC_CTL_SFTRST 1
`define IEDC_CTL_MODULE_ENABLE 0
`define IEDC_INTF_SCLLOW 11
`define IEDC_INTF_BSY 10
`define IEDC_F_BYTEEND 7
`define IEDC_F_GC 6
`define IEDC_F_NACK 5
`define IEDC_F_STOP 4
`define IEDC_F_START 3
`define IEDC_F_ERR 2
`define IEDC_F_RBF 1
`define IEDC_F_TBE 0
// ==========================================================
// reset values and constants
`define IEDC_RST_FLAGS 8'h00
`define IEDC_RST_EN 8'h00
`define IEDC_GC_ADDR 7'h00
`endif

// ===== hw/iedc_pkg.sv
/*
  types of the i2c event/dma/clock block.
  assumes nothing of its surroundings.
*/
package iedc_pkg;
  // ==========================================================
  // clock source codes
  typedef enum logic [1:0] {
    IEDC_SRC_INTERNAL_OSCILLATOR = 2'h0,
    IEDC_SRC_LSX = 2'h1,
    IEDC_SRC_HSO = 2'h2,
    IEDC_SRC_EXT = 2'h3
  } iedc_src_t;
  // software reset sequencer: run, reset, release, back to run
  typedef enum logic [1:0] {
    IEDC_RUN = 2'b00,
    IEDC_RST = 2'b01,
    IEDC_REL = 2'b11
  } iedc_rst_t;
endpackage

// ===== hw/iedc_top.sv
/*
  event flags, interrupt and dma request gating, operating clock
  selection and own-address matching of one i2c channel, as an apb slave.
  assumes the byte engine on pclk gives one-cycle event pulses, and that
  the clock source and scl pins are asynchronous and need synchronising.
*/
// Our own choices: register access over APB and the address map.
// What this block does
// - set byte-end flag after byte plus ack bit; clear by write 1 or reset
// - slave only: set general-call flag on general call address
// - set nack flag whenever nack received; clear by write 1 or reset
// - master: stop flag set after stop generated and bus free time elapsed
// - slave: stop flag set on stop while this channel is addressed
// - start flag: master on start issued, slave on own or general match
// - receive-full flag set on buffer load, cleared by reading data
// - master: transmit-empty set on start issued or ack received
// - slave: transmit-empty set on shift load or read-address match
// - interrupt request only while an enabled flag is set
// - per dma channel rx/tx enables gate the request
// - debug run bit keeps operating clock during debug halt
// - two-bit source field picks one of four clock sources
// - divider 1/2/4/8 for internal and fast oscillator only
// - sources absent on the chip cannot be selected
// - mode bit 2 selects how many own-address bits compare
// - address width bit: 1 ten-bit, 0 seven-bit matching
// - general call enable bit 1 lets slave answer general call
// - start request with scl low and bus free: error, start flag
`timescale 1ns/1ns
`include "iedc_params.svh"
module iedc_top import iedc_pkg::*; #(
  parameter int DMA_CH = 4,
  parameter logic [3:0] SRC_PRESENT = 4'hf
) (
  input wire logic pclk, // bus clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [11:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic [3:0] src_clk_in, // raw clock sources
  input wire logic dbg_halt, // cpu halted for debug
  input wire logic scl_in, // scl pin level
  output logic op_clk_tick, // operating clock pulse
  input wire logic bus_busy, // bus busy from engine
  input wire logic ev_byte_end, // byte and ack done
  input wire logic ev_nack, // nack received
  input wire logic ev_stop_done, // master stop plus bus free time
  input wire logic ev_stop_det, // stop seen on bus
  input wire logic slave_sel, // channel addressed as slave
  input wire logic ev_start_done, // master start issued
  input wire logic ev_ack_rcvd, // master got ack
  input wire logic ev_err, // engine error
  input wire logic ev_addr, // slave address received
  input wire logic addr_is_10, // received address is 10-bit
  input wire logic [9:0] rx_addr, // received address
  input wire logic rx_rw, // received r/w bit
  output logic addr_match, // own or general call match
  input wire logic ev_rx_load, // rx buffer loaded
  input wire logic [7:0] rx_data, // byte to rx buffer
  input wire logic ev_tx_shift, // tx buffer moved to shifter
  output logic [7:0] tx_data, // tx buffer
  output logic start_request, // start request level
  output logic master_mode, // master selected
  output logic sw_reset, // software reset to engine
  output logic irq, // interrupt request
  output logic [DMA_CH-1:0] dma_rx_req, // receive dma request
  output logic [DMA_CH-1:0] dma_tx_req // transmit dma request
);
  if (DMA_CH < 1 || DMA_CH > 16) begin : g_bad_dma_ch
    $error("DMA_CH must be 1 to 16");
  end

  // ==========================================================
  // registers
  logic debug_run_q, own_address_width_q, general_call_enable_q;
  logic module_enable_q, mst_q, start_request_q;
  logic [1:0] clock_source_select_q, clock_divider_select_q;
  logic [7:0] flags_q, flags_d, inte_q, fset, fclr;
  logic [DMA_CH-1:0] dmarx_q, dmatx_q;
  logic [7:0] txd_q, rxd_q;
  logic [9:0] oadr_q;
  logic [31:0] prdata_q;
  iedc_rst_t rst_q;

  // ==========================================================
  // apb decode
  wire setup = psel & ~penable;
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire hit_clk = paddr == `IEDC_OFF_CLK;
  wire hit_mod = paddr == `IEDC_OFF_MOD;
  wire hit_ctl = paddr == `IEDC_OFF_CTL;
  wire hit_intf = paddr == `IEDC_OFF_INTF;
  wire hit_inte = paddr == `IEDC_OFF_INTE;
  wire hit_drx = paddr == `IEDC_OFF_DMARX;
  wire hit_dtx = paddr == `IEDC_OFF_DMATX;
  wire hit_txd = paddr == `IEDC_OFF_TXD;
  wire hit_rxd = paddr == `IEDC_OFF_RXD;
  wire hit_oadr = paddr == `IEDC_OFF_OADR;
  wire mapped = hit_clk | hit_mod | hit_ctl | hit_intf | hit_inte | hit_drx
    | hit_dtx | hit_txd | hit_rxd | hit_oadr;
  wire [1:0] wsrc = pwdata[`IEDC_CLK_SRC_LO +: 2];
  wire cfg_ok = ~module_enable_q;
  wire src_ok = SRC_PRESENT[wsrc];
  wire sftrst_wr = wr & hit_ctl & pwdata[`IEDC_CTL_SFTRST];
  wire start_wr = wr & hit_ctl & pwdata[`IEDC_CTL_START_REQUEST] & pwdata[`IEDC_CTL_MST];
  wire soft_rst = rst_q != IEDC_RUN;

  assign pready = 1'b1;
  assign pslverr = acc & ~mapped;
  assign prdata = prdata_q;

  // ==========================================================
  // synchronisers and scl
  logic [3:0] src_m_q, src_s_q, src_p_q;
  logic scl_m_q, scl_s_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_m_q <= 4'h0;
      src_s_q <= 4'h0;
      src_p_q <= 4'h0;
      scl_m_q <= 1'b1;
      scl_s_q <= 1'b1;
    end else begin
      src_m_q <= src_clk_in;
      src_s_q <= src_m_q;
      src_p_q <= src_s_q;
      scl_m_q <= scl_in;
      scl_s_q <= scl_m_q;
    end
  end
  wire scl_low = ~scl_s_q;

  // ==========================================================
  // operating clock select and divide
  logic [2:0] div_cnt_q;
  wire [3:0] src_rise = src_s_q & ~src_p_q;
  wire sel_rise = src_rise[clock_source_select_q];
  wire divided = (clock_source_select_q == IEDC_SRC_INTERNAL_OSCILLATOR)
    | (clock_source_select_q == IEDC_SRC_HSO);
  wire [2:0] div_mask = divided ? 3'((4'h1 << clock_divider_select_q) - 4'h1) : 3'h0;
  wire clk_gate = module_enable_q & (~dbg_halt | debug_run_q);
  wire div_wrap = (div_cnt_q & div_mask) == div_mask;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_cnt_q <= 3'h0;
      op_clk_tick <= 1'b0;
    end else begin
      op_clk_tick <= clk_gate & sel_rise & div_wrap;
      if (!clk_gate) begin
        div_cnt_q <= 3'h0;
      end else if (sel_rise) begin
        div_cnt_q <= div_wrap ? 3'h0 : 3'(div_cnt_q + 3'h1);
      end
    end
  end

  // ==========================================================
  // own address match
  wire m7 = ~own_address_width_q & ~addr_is_10 & (rx_addr[6:0] == oadr_q[6:0]);
  wire m10 = own_address_width_q & addr_is_10 & (rx_addr == oadr_q);
  wire mgc = general_call_enable_q & ~addr_is_10 & (rx_addr[6:0] == `IEDC_GC_ADDR);
  wire slave_hit = ev_addr & ~mst_q & (m7 | m10 | mgc);
  assign addr_match = slave_hit;

  // ==========================================================
  // event flags
  wire scl_err = start_wr & ~bus_busy & scl_low;
  wire wr_intf = wr & hit_intf;
  always_comb begin
    fset = 8'h00;
    fset[`IEDC_F_BYTEEND] = ev_byte_end;
    fset[`IEDC_F_GC] = slave_hit & mgc & ~(m7 | m10);
    fset[`IEDC_F_NACK] = ev_nack;
    fset[`IEDC_F_STOP] = mst_q ? ev_stop_done : (ev_stop_det & slave_sel);
    fset[`IEDC_F_START] = (mst_q & ev_start_done) | slave_hit | scl_err;
    fset[`IEDC_F_ERR] = ev_err | scl_err;
    fset[`IEDC_F_RBF] = ev_rx_load;
    fset[`IEDC_F_TBE] = mst_q ? (ev_start_done | ev_ack_rcvd)
      : (ev_tx_shift | (slave_hit & rx_rw));
    fclr = wr_intf ? pwdata[7:0] : 8'h00;
    fclr[`IEDC_F_RBF] = rd & hit_rxd;
    fclr[`IEDC_F_TBE] = wr & hit_txd;
  end
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      // set wins over a same-cycle clear
      assign flags_d[gi] = soft_rst ? 1'b0 : (fset[gi] | (flags_q[gi] & ~fclr[gi]));
    end
  endgenerate

  assign irq = |(flags_q & inte_q);
  assign dma_rx_req = flags_q[`IEDC_F_RBF] ? dmarx_q : '0;
  assign dma_tx_req = flags_q[`IEDC_F_TBE] ? dmatx_q : '0;
  assign tx_data = txd_q;
  assign start_request = start_request_q;
  assign master_mode = mst_q;
  assign sw_reset = soft_rst;

  // ==========================================================
  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      debug_run_q <= 1'b0;
      clock_source_select_q <= 2'h0;
      clock_divider_select_q <= 2'h0;
      own_address_width_q <= 1'b0;
      general_call_enable_q <= 1'b0;
      module_enable_q <= 1'b0;
      mst_q <= 1'b0;
      inte_q <= `IEDC_RST_EN;
      dmarx_q <= '0;
      dmatx_q <= '0;
      txd_q <= 8'h00;
      oadr_q <= 10'h000;
    end else begin
      if (wr & hit_clk & cfg_ok) begin
        debug_run_q <= pwdata[`IEDC_CLK_DEBUG_RUN];
        clock_divider_select_q <= pwdata[`IEDC_CLK_DIV_LO +: 2];
        if (src_ok) begin
          clock_source_select_q <= wsrc;
        end
      end
      if (wr & hit_mod & cfg_ok) begin
        own_address_width_q <= pwdata[`IEDC_MOD_OWN_ADDRESS_WIDTH];
        general_call_enable_q <= pwdata[`IEDC_MOD_GENERAL_CALL_ENABLE];
      end
      if (wr & hit_oadr & cfg_ok) begin
        oadr_q <= pwdata[9:0];
      end
      if (wr & hit_ctl) begin
        module_enable_q <= pwdata[`IEDC_CTL_MODULE_ENABLE];
        mst_q <= pwdata[`IEDC_CTL_MST];
      end
      if (wr & hit_inte) begin
        inte_q <= pwdata[7:0];
      end
      if (wr & hit_drx) begin
        dmarx_q <= pwdata[DMA_CH-1:0];
      end
      if (wr & hit_dtx) begin
        dmatx_q <= pwdata[DMA_CH-1:0];
      end
      if (wr & hit_txd) begin
        txd_q <= pwdata[7:0];
      end
    end
  end

  // ==========================================================
  // flags, rx buffer, start request, software reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= `IEDC_RST_FLAGS;
      rxd_q <= 8'h00;
      start_request_q <= 1'b0;
      rst_q <= IEDC_RUN;
    end else begin
      flags_q <= flags_d;
      if (ev_rx_load) begin
        rxd_q <= rx_data;
      end
      if (soft_rst | ev_start_done | scl_err) begin
        start_request_q <= 1'b0;
      end else if (start_wr) begin
        start_request_q <= 1'b1;
      end
      case (rst_q)
        IEDC_RUN: rst_q <= sftrst_wr ? IEDC_RST : IEDC_RUN;
        IEDC_RST: rst_q <= IEDC_REL;
        IEDC_REL: rst_q <= IEDC_RUN;
        default: rst_q <= IEDC_RUN;
      endcase
    end
  end

  // ==========================================================
  // read data, captured in the setup cycle
  wire [31:0] rd_mux =
    hit_clk ? {23'h0, debug_run_q, 2'h0, clock_divider_select_q, 2'h0,
      clock_source_select_q} :
    hit_mod ? {29'h0, own_address_width_q, general_call_enable_q, 1'b0} :
    hit_ctl ? {26'h0, mst_q, 1'b0, 1'b0, start_request_q, soft_rst, module_enable_q} :
    hit_intf ? {20'h0, scl_low, bus_busy, 2'h0, flags_q} :
    hit_inte ? {24'h0, inte_q} :
    hit_drx ? 32'(dmarx_q) :
    hit_dtx ? 32'(dmatx_q) :
    hit_txd ? {24'h0, txd_q} :
    hit_rxd ? {24'h0, rxd_q} :
    hit_oadr ? {22'h0, oadr_q} : 32'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0;
    end else if (setup) begin
      prdata_q <= rd_mux;
    end
  end

  // ==========================================================
  // checks
  chk_byte_end_set: assert property (@(posedge pclk) disable iff (!presetn)
    ev_byte_end & ~soft_rst |=> flags_q[`IEDC_F_BYTEEND])
    else $error("byte end flag not set");
  chk_nack_hold: assert property (@(posedge pclk) disable iff (!presetn)
    flags_q[`IEDC_F_NACK] & ~soft_rst & ~(wr_intf & pwdata[`IEDC_F_NACK])
      |=> flags_q[`IEDC_F_NACK])
    else $error("nack flag lost");
  chk_slave_stop: assert property (@(posedge pclk) disable iff (!presetn)
    ~mst_q & ev_stop_det & ~slave_sel & ~flags_q[`IEDC_F_STOP]
      |=> ~flags_q[`IEDC_F_STOP])
    else $error("stop flag set while not addressed");
  chk_rbf_clear: assert property (@(posedge pclk) disable iff (!presetn)
    rd & hit_rxd & ~ev_rx_load |=> ~flags_q[`IEDC_F_RBF])
    else $error("rx full not cleared by read");
  chk_tbe_master: assert property (@(posedge pclk) disable iff (!presetn)
    mst_q & ev_ack_rcvd & ~soft_rst |=> flags_q[`IEDC_F_TBE])
    else $error("tx empty not set on ack");
  chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
    ((fset & inte_q) != 8'h00) & ~soft_rst & ~(wr & hit_inte) |=> irq)
    else $error("irq not matching enabled flags");
  chk_dma_gate: assert property (@(posedge pclk) disable iff (!presetn)
    dma_rx_req != '0 |-> flags_q[`IEDC_F_RBF])
    else $error("dma rx request without flag");
  chk_debug_stop: assert property (@(posedge pclk) disable iff (!presetn)
    dbg_halt & ~debug_run_q |=> ~op_clk_tick)
    else $error("clock ran during debug halt");
  chk_scl_error: assert property (@(posedge pclk) disable iff (!presetn)
    scl_err & ~soft_rst |=> flags_q[`IEDC_F_ERR] & flags_q[`IEDC_F_START] & ~start_request_q)
    else $error("scl low start not reported");
  chk_src_absent: assert property (@(posedge pclk) disable iff (!presetn)
    SRC_PRESENT[clock_source_select_q] | (clock_source_select_q == IEDC_SRC_INTERNAL_OSCILLATOR))
    else $error("absent clock source selected");
endmodule

// ===== tb/iedc_eng_model.sv
/*
  far side of the channel: free-running clock sources, scl level and
  one-cycle engine event pulses.
  assumes pclk from the bench; the bench calls fire and sets scl.
*/
`timescale 1ns/1ns
module iedc_eng_model (
  input wire logic pclk, // bus clock
  output logic [3:0] src_clk, // raw clock sources
  output logic scl, // scl level, pulled up
  output logic [9:0] ev // event pulses
);
  // ==========================================================
  // sources: period 320+160k ns, phase off pclk
  initial begin
    src_clk = 4'h0;
    scl = 1'b1;
    ev = 10'h000;
  end
  for (genvar k = 0; k < 4; k++) begin : g_src
    initial begin
      #(7 + 3 * k);
      forever #(160 + 80 * k) src_clk[k] = ~src_clk[k];
    end
  end
  // ==========================================================
  // scl level change, launched just after a rising edge
  task automatic set_scl(input logic v);
    @(posedge pclk);
    scl <= v;
  endtask
  // ==========================================================
  // one-cycle pulse, returns once it has been sampled
  task automatic fire(input int i);
    @(posedge pclk);
    ev <= 10'h001 << i;
    @(posedge pclk);
    ev <= 10'h000;
    @(negedge pclk);
  endtask
endmodule

// ===== tb/tb_i2c_event_dma_clock_setup.sv
/*
  self-checking bench of the event, dma, clock and address logic.
  assumes the apb slave and the far-side model iedc_eng_model.
*/
`timescale 1ns/1ns
`include "iedc_params.svh"
module tb_i2c_event_dma_clock_setup import iedc_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q, dbg_halt;
  logic op_clk_tick, slave_sel, addr_is_10, rx_rw, addr_match, am_seen;
  logic start_request, master_mode, sw_reset, irq, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q, exp_f, lf, m;
  logic [9:0] rx_addr, ev;
  logic [7:0] rx_data, tx_data;
  logic [3:0] src, dma_rx_req, dma_tx_req;
  logic scl;
  int n_mismatch, tests_run, ticks, cyc;
  iedc_eng_model u_eng (.pclk(pclk), .src_clk(src), .scl(scl), .ev(ev));
  iedc_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .src_clk_in(src), .dbg_halt(dbg_halt), .scl_in(scl), .op_clk_tick(op_clk_tick),
    .bus_busy(busy), .ev_byte_end(ev[0]), .ev_nack(ev[1]), .ev_stop_done(ev[2]),
    .ev_stop_det(ev[3]), .slave_sel(slave_sel), .ev_start_done(ev[4]),
    .ev_ack_rcvd(ev[5]), .ev_err(ev[6]), .ev_addr(ev[7]), .addr_is_10(addr_is_10),
    .rx_addr(rx_addr), .rx_rw(rx_rw), .addr_match(addr_match), .ev_rx_load(ev[8]),
    .rx_data(rx_data), .ev_tx_shift(ev[9]), .tx_data(tx_data),
    .start_request(start_request), .master_mode(master_mode), .sw_reset(sw_reset),
    .irq(irq), .dma_rx_req(dma_rx_req), .dma_tx_req(dma_tx_req));
  // ==========================================================
  // clock, watchdog, tick and match capture
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (op_clk_tick === 1'b1) ticks++;
    if (ev[7]) am_seen <= addr_match;
    if (cyc == 40000) begin
      n_mismatch++;
      conclude();
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_mismatch++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd_q, e);
  endtask
  task near(input int e);
    chk(32'((ticks >= e - 1) && (ticks <= e + 1)), 32'h1);
  endtask
  // event, then flags, then write-1 clear of bits 7..2
  task evt(input int i, input logic [31:0] bits, input logic am);
    am_seen = 1'b0;
    u_eng.fire(i);
    exp_f = exp_f | bits;
    rd(`IEDC_OFF_INTF, exp_f);
    if (i == 7) chk(am_seen, am);
    wr(`IEDC_OFF_INTF, 32'hfc);
    exp_f = exp_f & 32'h3;
  endtask
  task adr(input logic [9:0] a, input logic rw, input logic ten, input logic [31:0] b,
           input logic am);
    @(posedge pclk);
    rx_addr <= a;
    rx_rw <= rw;
    addr_is_10 <= ten;
    evt(7, b, am);
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, dbg_halt, slave_sel, addr_is_10, rx_rw, busy} = 9'h000;
    {paddr, pwdata, rx_addr, rx_data} = '0;
    {n_mismatch, tests_run, ticks, cyc} = '0;
    exp_f = 32'h0;
    lf = 32'd39;
    am_seen = 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 10; i++) rd(12'(4 * i), 32'h0);
    rd(12'h030, 32'h0);
    chk(err_q, 32'h1);
    $display("test reset done");
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        wr(`IEDC_OFF_CTL, 32'h0);
        wr(`IEDC_OFF_CLK, 32'((d << 4) | s));
        wr(`IEDC_OFF_CTL, 32'h1);
        ticks = 0;
        repeat (256) @(posedge pclk);
        near(10240 / (320 + 160 * s) / ((s == 1 || s == 3) ? 1 : (1 << d)));
      end
    end
    wr(`IEDC_OFF_CLK, 32'h100);
    rd(`IEDC_OFF_CLK, 32'h33);
    wr(`IEDC_OFF_CTL, 32'h0);
    wr(`IEDC_OFF_CLK, 32'h0);
    wr(`IEDC_OFF_CTL, 32'h1);
    @(posedge pclk);
    dbg_halt <= 1'b1;
    repeat (8) @(posedge pclk);
    @(negedge pclk);
    ticks = 0;
    repeat (256) @(posedge pclk);
    chk(ticks, 32'h0);
    wr(`IEDC_OFF_CTL, 32'h0);
    wr(`IEDC_OFF_CLK, 32'h100);
    wr(`IEDC_OFF_CTL, 32'h1);
    ticks = 0;
    repeat (256) @(posedge pclk);
    near(32);
    dbg_halt <= 1'b0;
    $display("test clocks done");
    wr(`IEDC_OFF_CTL, 32'h0);
    wr(`IEDC_OFF_MOD, 32'h2);
    wr(`IEDC_OFF_OADR, 32'h5a);
    wr(`IEDC_OFF_CTL, 32'h1);
    evt(0, 32'h80, 1'b0);
    evt(6, 32'h04, 1'b0);
    u_eng.fire(1);
    chk(irq, 32'h0);
    wr(`IEDC_OFF_INTE, 32'h20);
    chk(irq, 32'h1);
    wr(`IEDC_OFF_INTE, 32'hdf);
    chk(irq, 32'h0);
    u_eng.fire(0);
    chk(irq, 32'h1);
    evt(1, 32'ha0, 1'b0);
    wr(`IEDC_OFF_INTE, 32'h0);
    evt(3, 32'h0, 1'b0);
    @(posedge pclk);
    slave_sel <= 1'b1;
    evt(3, 32'h10, 1'b0);
    adr(10'h05a, 1'b0, 1'b0, 32'h08, 1'b1);
    adr(10'h05a, 1'b1, 1'b0, 32'h09, 1'b1);
    adr(10'h000, 1'b0, 1'b0, 32'h48, 1'b1);
    lf = lfsr(lf);
    adr((lf[6:0] == 7'h5a || lf[6:0] == 7'h00) ? 10'h011 : {3'h0, lf[6:0]}, 1'b0, 1'b0,
        32'h0, 1'b0);
    m = {28'h0, lf[3:1], 1'b1};
    wr(`IEDC_OFF_DMARX, m);
    lf = lfsr(lf);
    @(posedge pclk);
    rx_data <= lf[7:0];
    u_eng.fire(8);
    chk(dma_rx_req, m);
    rd(`IEDC_OFF_RXD, lf[7:0]);
    chk(dma_rx_req, 32'h0);
    wr(`IEDC_OFF_DMARX, 32'h0);
    wr(`IEDC_OFF_DMATX, m);
    chk(dma_tx_req, m);
    lf = lfsr(lf);
    wr(`IEDC_OFF_TXD, lf[7:0]);
    chk(tx_data, lf[7:0]);
    chk(dma_tx_req, 32'h0);
    u_eng.fire(9);
    chk(dma_tx_req, m);
    wr(`IEDC_OFF_TXD, 32'h0);
    wr(`IEDC_OFF_DMATX, 32'h0);
    exp_f = 32'h0;
    wr(`IEDC_OFF_CTL, 32'h0);
    wr(`IEDC_OFF_MOD, 32'h4);
    wr(`IEDC_OFF_OADR, 32'h2a5);
    wr(`IEDC_OFF_CTL, 32'h1);
    adr(10'h2a5, 1'b0, 1'b1, 32'h08, 1'b1);
    adr(10'h0a5, 1'b0, 1'b1, 32'h0, 1'b0);
    adr(10'h000, 1'b0, 1'b0, 32'h0, 1'b0);
    $display("test slave done");
    wr(`IEDC_OFF_CTL, 32'h21);
    chk(master_mode, 32'h1);
    u_eng.set_scl(1'b0);
    @(posedge pclk);
    busy <= 1'b1;
    repeat (4) @(posedge pclk);
    wr(`IEDC_OFF_CTL, 32'h25);
    chk(start_request, 32'h1);
    rd(`IEDC_OFF_INTF, 32'hc00);
    @(posedge pclk);
    busy <= 1'b0;
    wr(`IEDC_OFF_CTL, 32'h25);
    chk(start_request, 32'h0);
    rd(`IEDC_OFF_INTF, 32'h80c);
    wr(`IEDC_OFF_INTF, 32'hfc);
    u_eng.set_scl(1'b1);
    repeat (4) @(posedge pclk);
    wr(`IEDC_OFF_CTL, 32'h25);
    chk(start_request, 32'h1);
    evt(4, 32'h09, 1'b0);
    chk(start_request, 32'h0);
    wr(`IEDC_OFF_TXD, 32'h0);
    exp_f = 32'h0;
    evt(5, 32'h01, 1'b0);
    evt(2, 32'h10, 1'b0);
    u_eng.fire(0);
    wr(`IEDC_OFF_CTL, 32'h23);
    chk(sw_reset, 32'h1);
    repeat (4) @(posedge pclk);
    chk(sw_reset, 32'h0);
    rd(`IEDC_OFF_INTF, 32'h0);
    $display("test master done");
    conclude();
  end
endmodule
